//--- hw/pack_monitor_control_regs.sv
`timescale 1ns/1ps
`include "pack_monitor_map.svh"
module pack_monitor_control_regs #(
	parameter logic [6:0] DEVICE_ADDR = 7'h2A
) (
	// Clock and reset
	input wire logic CLOCK,
	input wire logic SYS_RST,
	// Serial register link
	input wire logic SCL,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE,
	// Protection events, auto-response disables and wake-up
	input wire pack_monitor_pkg::fault_t FAULT,
	input wire pack_monitor_pkg::fault_t AUTO_DISABLE,
	input wire logic WAKE,
	// Power stage and monitor
	output pack_monitor_pkg::drive_t DRIVE,
	output logic BALANCE_CLEAR,
	output logic [3:0] MONITOR_SOURCE,
	output logic USER_FLAG_HIGH,
	output logic USER_FLAG_LOW,
	// Status-set pulses
	output pack_monitor_pkg::status_set_t STATUS_SET
);
	import pack_monitor_pkg::*;

	state_t r;
	state_t next_r;
	logic scl_s;
	logic sda_s;
	logic wake_s;
	fault_t fault_s;
	fault_t disable_s;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	// Named copies so single fields of the reset words can be selected
	localparam logic [7:0] analog_reset_value = `ANALOG_OUT_CONTROL_RESET;
	localparam logic [7:0] fet_reset_value = `FET_DRIVE_CONTROL_RESET;

	// Every pin from outside the clock domain is synchronised
	pin_sync #(
		.WIDTH(9),
		.INIT(9'h180)
	) u_sync (
		.clk(CLOCK),
		.rst(SYS_RST),
		.d({SCL, SDA_IN, WAKE, FAULT, AUTO_DISABLE}),
		.q({scl_s, sda_s, wake_s, fault_s, disable_s})
	);

	function automatic logic [7:0] read_reg(input state_t s,
			input logic [7:0] a);
		case (a)
			`ANALOG_OUT_CONTROL_ADDR: read_reg = {s.user_flag_high,
				s.user_flag_low, 2'h0, s.monitor_select};
			`FET_DRIVE_CONTROL_ADDR: read_reg = {s.sleep,
				s.load_monitor_enable, 4'h0,
				s.charge_switch_enable, s.discharge_switch_enable};
			default: read_reg = 8'h00;
		endcase
	endfunction

	function automatic state_t write_reg(input state_t s,
			input logic [7:0] a, input logic [7:0] d);
		state_t w;
		w = s;
		case (a)
			`ANALOG_OUT_CONTROL_ADDR: begin
				w.user_flag_high = d[`USER_FLAG_HIGH_BIT];
				w.user_flag_low = d[`USER_FLAG_LOW_BIT];
				w.monitor_select =
					d[`MONITOR_SELECT_MSB:`MONITOR_SELECT_LSB];
			end
			`FET_DRIVE_CONTROL_ADDR: begin
				w.load_monitor_enable = d[`LOAD_MONITOR_BIT];
				w.charge_switch_enable = d[`CHARGE_SWITCH_BIT];
				w.discharge_switch_enable =
					d[`DISCHARGE_SWITCH_BIT];
				if (d[`FORCE_SLEEP_BIT] && !s.sleep) begin
					w.sleep = 1'b1;
					w.balance_clear = 1'b1;
				end
			end
			default: w = s;
		endcase
		return w;
	endfunction

	function automatic logic [3:0] monitor_route(input logic [3:0] sel);
		if (sel <= `MONITOR_INT_TEMP)
			monitor_route = sel;
		else
			monitor_route = `MONITOR_OFF;
	endfunction

	assign scl_rise = scl_s && !r.scl_q;
	assign scl_fall = !scl_s && r.scl_q;
	assign start_seen = scl_s && r.scl_q && r.sda_q && !sda_s;
	assign stop_seen = scl_s && r.scl_q && !r.sda_q && sda_s;

	always_comb begin
		next_r = r;
		next_r.scl_q = scl_s;
		next_r.sda_q = sda_s;
		next_r.balance_clear = 1'b0;
		if (start_seen) begin
			next_r.state = ST_ADDR;
			next_r.bit_cnt = 4'h0;
			next_r.sda_oe = 1'b0;
		end else if (stop_seen) begin
			next_r.state = ST_IDLE;
			next_r.sda_oe = 1'b0;
		end else begin
			case (r.state)
				ST_IDLE: begin
					next_r.sda_oe = 1'b0;
				end
				ST_ADDR, ST_PTR, ST_WDATA: begin
					if (scl_rise) begin
						next_r.shift = {r.shift[6:0], sda_s};
						next_r.bit_cnt = r.bit_cnt + 4'h1;
					end else if (scl_fall &&
							r.bit_cnt == `BITS_PER_BYTE) begin
						next_r.sda_oe = 1'b1;
						if (r.state == ST_ADDR) begin
							if (r.shift[7:1] == DEVICE_ADDR) begin
								next_r.rw = r.shift[0];
								next_r.state = ST_ACK_ADDR;
							end else begin
								next_r.sda_oe = 1'b0;
								next_r.state = ST_IDLE;
							end
						end else if (r.state == ST_PTR) begin
							next_r.ptr = r.shift;
							next_r.state = ST_ACK_PTR;
						end else begin
							next_r = write_reg(next_r, r.ptr, r.shift);
							next_r.ptr = r.ptr + 8'h01;
							next_r.state = ST_ACK_DATA;
						end
					end
				end
				ST_ACK_ADDR: begin
					if (scl_fall) begin
						next_r.bit_cnt = 4'h0;
						if (r.rw) begin
							next_r.shift = read_reg(r, r.ptr);
							next_r.sda_oe = !next_r.shift[7];
							next_r.ptr = r.ptr + 8'h01;
							next_r.state = ST_TX;
						end else begin
							next_r.sda_oe = 1'b0;
							next_r.state = ST_PTR;
						end
					end
				end
				ST_ACK_PTR, ST_ACK_DATA: begin
					if (scl_fall) begin
						next_r.sda_oe = 1'b0;
						next_r.bit_cnt = 4'h0;
						next_r.state = ST_WDATA;
					end
				end
				ST_TX: begin
					if (scl_rise) begin
						next_r.bit_cnt = r.bit_cnt + 4'h1;
					end else if (scl_fall) begin
						if (r.bit_cnt == `BITS_PER_BYTE) begin
							next_r.sda_oe = 1'b0;
							next_r.state = ST_RACK;
						end else begin
							next_r.shift = {r.shift[6:0], 1'b1};
							next_r.sda_oe = !r.shift[6];
						end
					end
				end
				ST_RACK: begin
					if (scl_rise) begin
						next_r.nack = sda_s;
					end else if (scl_fall) begin
						if (r.nack) begin
							next_r.state = ST_IDLE;
						end else begin
							next_r.shift = read_reg(r, r.ptr);
							next_r.sda_oe = !next_r.shift[7];
							next_r.ptr = r.ptr + 8'h01;
							next_r.bit_cnt = 4'h0;
							next_r.state = ST_TX;
						end
					end
				end
				default: begin
					next_r.state = ST_IDLE;
					next_r.sda_oe = 1'b0;
				end
			endcase
		end

		// Hardware clears win over a software write in the same cycle,
		// so a fault can never be overridden by a racing register write
		if (fault_s.charge_oc && !disable_s.charge_oc)
			next_r.charge_switch_enable = 1'b0;
		if ((fault_s.discharge_oc && !disable_s.discharge_oc) ||
				(fault_s.short_circuit && !disable_s.short_circuit))
			next_r.discharge_switch_enable = 1'b0;

		// Sleep holds both switches off; selector and flags persist
		if (next_r.sleep) begin
			next_r.charge_switch_enable = 1'b0;
			next_r.discharge_switch_enable = 1'b0;
		end
		if (wake_s)
			next_r.sleep = 1'b0;

		// Status pulses fire on each new event, disabled or not
		next_r.fault_q = fault_s;
		next_r.status_set.charge_oc_set =
			fault_s.charge_oc && !r.fault_q.charge_oc;
		next_r.status_set.discharge_oc_set =
			fault_s.discharge_oc && !r.fault_q.discharge_oc;
		next_r.status_set.short_circuit_set =
			fault_s.short_circuit && !r.fault_q.short_circuit;

		next_r.monitor_out = monitor_route(next_r.monitor_select);

		if (SYS_RST) begin
			next_r = '0;
			next_r.state = ST_IDLE;
			next_r.scl_q = 1'b1;
			next_r.sda_q = 1'b1;
			{next_r.user_flag_high, next_r.user_flag_low, next_r.monitor_select}
				= {analog_reset_value[7:6], analog_reset_value[3:0]};
			{next_r.sleep, next_r.load_monitor_enable}
				= fet_reset_value[7:6];
			{next_r.charge_switch_enable, next_r.discharge_switch_enable}
				= fet_reset_value[1:0];
		end
	end

	always_ff @(posedge CLOCK) begin
		r <= next_r;
	end

	// The link only ever pulls low
	assign SDA_OUT = 1'b0;
	assign SDA_OE = r.sda_oe;
	assign DRIVE.regulator_output = !r.sleep;
	assign DRIVE.load_monitor_circuit = r.load_monitor_enable;
	assign DRIVE.charge_switch = r.charge_switch_enable;
	assign DRIVE.discharge_switch = r.discharge_switch_enable;
	assign BALANCE_CLEAR = r.balance_clear;
	assign MONITOR_SOURCE = r.monitor_out;
	assign USER_FLAG_HIGH = r.user_flag_high;
	assign USER_FLAG_LOW = r.user_flag_low;
	assign STATUS_SET = r.status_set;
endmodule // pack_monitor_control_regs

//--- hw/pack_monitor_map.svh
`ifndef PACK_MONITOR_MAP_SVH
`define PACK_MONITOR_MAP_SVH

// Register offsets on the serial link
`define ANALOG_OUT_CONTROL_ADDR 8'h03
`define FET_DRIVE_CONTROL_ADDR 8'h04

// Analog output control fields
`define USER_FLAG_HIGH_BIT 7
`define USER_FLAG_LOW_BIT 6
`define MONITOR_SELECT_MSB 3
`define MONITOR_SELECT_LSB 0

// FET drive control fields
`define FORCE_SLEEP_BIT 7
`define LOAD_MONITOR_BIT 6
`define CHARGE_SWITCH_BIT 1
`define DISCHARGE_SWITCH_BIT 0

// Reset values
`define ANALOG_OUT_CONTROL_RESET 8'h00
`define FET_DRIVE_CONTROL_RESET 8'h00

// Monitor selector codes
`define MONITOR_OFF 4'h0
`define MONITOR_CELL_LAST 4'h7
`define MONITOR_EXT_TEMP 4'h8
`define MONITOR_INT_TEMP 4'h9

// Serial link timing: bits per byte
`define BITS_PER_BYTE 4'h8

`endif

//--- hw/pack_monitor_pkg.sv
package pack_monitor_pkg;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ACK_ADDR,
		ST_PTR,
		ST_ACK_PTR,
		ST_WDATA,
		ST_ACK_DATA,
		ST_TX,
		ST_RACK
	} link_state_t;

	// Protection events and their auto-response disables
	typedef struct packed {
		logic charge_oc;
		logic discharge_oc;
		logic short_circuit;
	} fault_t;

	// Power-stage drive outputs
	typedef struct packed {
		logic regulator_output;
		logic load_monitor_circuit;
		logic charge_switch;
		logic discharge_switch;
	} drive_t;

	// Status-set pulses toward the status register
	typedef struct packed {
		logic charge_oc_set;
		logic discharge_oc_set;
		logic short_circuit_set;
	} status_set_t;

	typedef struct packed {
		link_state_t state;
		logic scl_q;
		logic sda_q;
		logic [3:0] bit_cnt;
		logic [7:0] shift;
		logic rw;
		logic nack;
		logic [7:0] ptr;
		logic sda_oe;
		logic user_flag_high;
		logic user_flag_low;
		logic [3:0] monitor_select;
		logic [3:0] monitor_out;
		logic sleep;
		logic load_monitor_enable;
		logic charge_switch_enable;
		logic discharge_switch_enable;
		logic balance_clear;
		fault_t fault_q;
		status_set_t status_set;
	} state_t;

endpackage

//--- hw/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Pins in, synchronised levels out
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] stage1;

	always_ff @(posedge clk) begin
		if (rst) begin
			stage1 <= INIT;
			q <= INIT;
		end else begin
			stage1 <= d;
			q <= stage1;
		end
	end
endmodule // pin_sync

//--- test/pack_monitor_asserts.sv
`timescale 1ns/1ps
module pack_monitor_asserts #(
	parameter logic [6:0] DEVICE_ADDR = 7'h2A
) (
	// Clock and reset
	input wire logic CLOCK,
	input wire logic SYS_RST,
	// Serial link
	input wire logic SCL,
	input wire logic SDA_IN,
	input wire logic SDA_OUT,
	input wire logic SDA_OE,
	// Events
	input wire pack_monitor_pkg::fault_t FAULT,
	input wire pack_monitor_pkg::fault_t AUTO_DISABLE,
	input wire logic WAKE,
	// Outputs
	input wire pack_monitor_pkg::drive_t DRIVE,
	input wire logic BALANCE_CLEAR,
	input wire logic [3:0] MONITOR_SOURCE,
	input wire logic USER_FLAG_HIGH,
	input wire logic USER_FLAG_LOW,
	input wire pack_monitor_pkg::status_set_t STATUS_SET
);
	import pack_monitor_pkg::*;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (SYS_RST);
	sda_low_a: assert property (SDA_OUT == 1'b0)
		else $error("sda data driven high");
	source_range_a: assert property (MONITOR_SOURCE <= 4'h9)
		else $error("reserved source routed");
	sleep_fets_a: assert property (!DRIVE.regulator_output |->
		!DRIVE.charge_switch && !DRIVE.discharge_switch)
		else $error("switch on in sleep");
	sleep_entry_a: assert property ($fell(DRIVE.regulator_output) |->
		BALANCE_CLEAR ##1 !BALANCE_CLEAR)
		else $error("no balance clear on sleep");
	sleep_select_a: assert property ($fell(DRIVE.regulator_output) |->
		$stable(MONITOR_SOURCE)) else $error("source moved on sleep");
	wake_clear_a: assert property (WAKE[*4] |=> DRIVE.regulator_output)
		else $error("sleep kept after wake");
	charge_trip_a: assert property ((FAULT.charge_oc &&
		!AUTO_DISABLE.charge_oc)[*4] |=> !DRIVE.charge_switch)
		else $error("charge switch kept on fault");
	dis_trip_a: assert property (((FAULT.discharge_oc &&
		!AUTO_DISABLE.discharge_oc) || (FAULT.short_circuit &&
		!AUTO_DISABLE.short_circuit))[*4] |=> !DRIVE.discharge_switch)
		else $error("discharge switch kept on fault");
	oc_status_a: assert property ($rose(FAULT.discharge_oc) |->
		##[1:5] STATUS_SET.discharge_oc_set) else $error("no oc status");
	sc_status_a: assert property ($rose(FAULT.short_circuit) |->
		##[1:5] STATUS_SET.short_circuit_set) else $error("no sc status");
	coc_status_a: assert property ($rose(FAULT.charge_oc) |->
		##[1:5] STATUS_SET.charge_oc_set) else $error("no coc status");
	// Data may only move while the clock is low, or it reads as start/stop
	sda_hold_a: assert property ($changed(SDA_OE) |-> !SCL)
		else $error("sda moved with scl high");
	cover property ($fell(DRIVE.regulator_output));
	cover property ($fell(DRIVE.charge_switch));
	cover property (STATUS_SET.short_circuit_set && DRIVE.discharge_switch);
endmodule // pack_monitor_asserts
bind pack_monitor_control_regs pack_monitor_asserts #(
	.DEVICE_ADDR(DEVICE_ADDR)) u_chk (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
	.SCL(SCL), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
	.FAULT(FAULT), .AUTO_DISABLE(AUTO_DISABLE), .WAKE(WAKE),
	.DRIVE(DRIVE), .BALANCE_CLEAR(BALANCE_CLEAR),
	.MONITOR_SOURCE(MONITOR_SOURCE), .USER_FLAG_HIGH(USER_FLAG_HIGH),
	.USER_FLAG_LOW(USER_FLAG_LOW), .STATUS_SET(STATUS_SET));

//--- test/i2c_host_model.sv
`timescale 1ns/1ps
module i2c_host_model #(
	parameter logic [6:0] DEVICE_ADDR = 7'h2A
) (
	// Clock and wire level
	input wire logic clock,
	input wire logic sda_wire,
	// Pins, high means released
	output logic scl,
	output logic sda,
	// Results
	output logic nacked,
	output logic rd_valid,
	output logic [7:0] rd_data
);
	initial begin
		scl = 1'b1;
		sda = 1'b1;
		nacked = 1'b0;
		rd_valid = 1'b0;
		rd_data = 8'h00;
	end
	// Five cycles per phase keeps each SCL level above four clocks
	task automatic half();
		repeat (5) @(posedge clock);
	endtask
	task automatic bit_io(input logic b, output logic r);
		sda <= b;
		half();
		scl <= 1'b1;
		half();
		r = sda_wire;
		scl <= 1'b0;
		half();
	endtask
	task automatic start();
		sda <= 1'b1;
		half();
		scl <= 1'b1;
		half();
		sda <= 1'b0;
		half();
		scl <= 1'b0;
		half();
	endtask
	task automatic stop();
		sda <= 1'b0;
		half();
		scl <= 1'b1;
		half();
		sda <= 1'b1;
		half();
	endtask
	task automatic put(input logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, r);
		if (r) nacked <= 1'b1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		start();
		put({DEVICE_ADDR, 1'b0});
		put(a);
		put(d);
		stop();
	endtask
	task automatic rd(input logic [7:0] a, input int n);
		logic [7:0] v;
		logic r;
		start();
		put({DEVICE_ADDR, 1'b0});
		put(a);
		start();
		put({DEVICE_ADDR, 1'b1});
		for (int k = 0; k < n; k++) begin
			for (int i = 7; i >= 0; i--) begin
				bit_io(1'b1, r);
				v[i] = r;
			end
			rd_data <= v;
			rd_valid <= 1'b1;
			@(posedge clock);
			rd_valid <= 1'b0;
			bit_io(k == n - 1, r);
		end
		stop();
	endtask
endmodule // i2c_host_model

//--- test/testbench.sv
`timescale 1ns/1ps
`include "pack_monitor_map.svh"
module testbench;
	import pack_monitor_pkg::*;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic wake = 1'b0;
	fault_t fault = 3'h0;
	fault_t auto_dis = 3'h0;
	drive_t drive;
	status_set_t st_set;
	logic scl, sda, sda_out, sda_oe, bal_clr, ufh, ufl;
	logic nacked, rd_valid;
	logic [7:0] rd_data, v, e;
	logic [3:0] mon_src;
	logic [7:0] expq[$];
	int miscompares = 0;
	int checks = 0;
	integer seed = 32'h02A7;
	wire logic sda_wire;
	// Pull-up: low whenever either party pulls the wire down
	assign sda_wire = sda & !(sda_oe & !sda_out);
	always #12.5 clock = ~clock;
	pack_monitor_control_regs u_dut (.CLOCK(clock), .SYS_RST(sys_rst),
		.SCL(scl), .SDA_IN(sda_wire), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
		.FAULT(fault), .AUTO_DISABLE(auto_dis), .WAKE(wake), .DRIVE(drive),
		.BALANCE_CLEAR(bal_clr), .MONITOR_SOURCE(mon_src),
		.USER_FLAG_HIGH(ufh), .USER_FLAG_LOW(ufl), .STATUS_SET(st_set));
	i2c_host_model u_host (.clock(clock), .sda_wire(sda_wire), .scl(scl),
		.sda(sda), .nacked(nacked), .rd_valid(rd_valid), .rd_data(rd_data));
	task automatic check(input string what, input logic [7:0] got, exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic results();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] x);
		expq.push_back(x);
		u_host.rd(a, 1);
	endtask
	always @(posedge clock) begin
		if (rd_valid)
			check("read", rd_data, expq.size() ? expq.pop_front() : 8'hXX);
	end
	initial begin
		repeat (100000) @(posedge clock);
		miscompares++;
		results();
	end
	initial begin
		repeat (16) @(posedge clock);
		sys_rst <= 1'b0;
		repeat (4) @(posedge clock);
		check("reset", 8'(drive), 8'h08);
		expq.push_back(8'h00);
		expq.push_back(8'h00);
		u_host.rd(`ANALOG_OUT_CONTROL_ADDR, 2);
		for (int c = 0; c < 16; c++) begin
			v = 8'($random(seed)) & 8'hC0 | 8'(c);
			u_host.wr(`ANALOG_OUT_CONTROL_ADDR, v);
			e = (c > 9) ? 8'h00 : 8'(c);
			check("source", {4'h0, mon_src}, e);
			check("flags", {6'h0, ufh, ufl}, {6'h0, v[7:6]});
			rd(`ANALOG_OUT_CONTROL_ADDR, v);
		end
		u_host.wr(`FET_DRIVE_CONTROL_ADDR, 8'h7F);
		check("fets", 8'(drive), 8'h0F);
		rd(`FET_DRIVE_CONTROL_ADDR, 8'h43);
		for (int i = 0; i < 6; i++) begin
			u_host.wr(`FET_DRIVE_CONTROL_ADDR, 8'h43);
			auto_dis <= (i > 2) ? 3'h7 : 3'h0;
			fault <= 3'(4 >> (i % 3));
			repeat (10) @(posedge clock);
			fault <= 3'h0;
			e = (i > 2) ? 8'h0F : (i == 0) ? 8'h0D : 8'h0E;
			check("fault", 8'(drive), e);
		end
		auto_dis <= 3'h0;
		u_host.wr(`ANALOG_OUT_CONTROL_ADDR, 8'hC5);
		u_host.wr(`FET_DRIVE_CONTROL_ADDR, 8'hC3);
		check("sleep", 8'(drive), 8'h04);
		check("source", {4'h0, mon_src}, 8'h05);
		check("flags", {6'h0, ufh, ufl}, 8'h03);
		rd(`FET_DRIVE_CONTROL_ADDR, 8'hC0);
		wake <= 1'b1;
		repeat (6) @(posedge clock);
		wake <= 1'b0;
		check("wake", 8'(drive), 8'h0C);
		rd(`FET_DRIVE_CONTROL_ADDR, 8'h40);
		u_host.wr(8'h07, 8'hFF);
		rd(8'h07, 8'h00);
		check("ack", {7'h0, nacked}, 8'h00);
		check("pending", 8'(expq.size()), 8'h00);
		results();
	end
endmodule // testbench
